//--- hw/rtcsc_top.sv
/*
  Status and configuration byte block of a battery-backed clock: the
  index and data ports, the control bytes A and B, the flag byte, the
  power-valid byte, the periodic rate divider and the configuration RAM.
  Assumes all inputs are synchronous to clk; time_base_tick is a
  one-cycle pulse at the time-base rate, alarm_match and update_done
  are one-cycle pulses from the timekeeping logic outside.
*/
`timescale 1ns/1ps
`include "rtcsc_defines.svh"
module rtcsc_top (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire rtcsc_pkg::rtcsc_port_t io_port,
  input  wire logic                 io_wr_stb,
  input  wire logic                 io_rd_stb,
  input  wire rtcsc_pkg::rtcsc_byte_t io_wdata,
  output      rtcsc_pkg::rtcsc_byte_t io_rdata,
  input  wire logic                 time_base_tick,
  input  wire logic                 alarm_match,
  input  wire logic                 update_done,
  input  wire logic                 update_busy,
  input  wire logic                 battery_ok,
  output      logic                 irq,
  output      logic                 nmi_mask
);
  import rtcsc_pkg::*;

  // True for the four bytes that live in logic rather than in the RAM.
  function automatic logic is_status(input rtcsc_index_t idx);
    is_status = (idx == `RTCSC_IDX_CTRL_A) || (idx == `RTCSC_IDX_CTRL_B) ||
                (idx == `RTCSC_IDX_FLAGS) || (idx == `RTCSC_IDX_POWER);
  endfunction

  // Periodic interval in time-base ticks, minus one; zero rate is off.
  function automatic logic [14:0] period_last(input logic [3:0] rs);
    logic [15:0] span;
    span = 16'h0001 << (rs - 4'h1);
    period_last = span[14:0] - 15'h0001;
  endfunction

  rtcsc_evt_if evt ();

  rtcsc_index_t index_ff;
  logic         nmi_mask_ff;
  rtcsc_byte_t  ctrl_a_ff;
  rtcsc_byte_t  ctrl_b_ff;
  logic         valid_ff;
  rtcsc_byte_t  rdata_ff;
  logic [14:0]  div_cnt_ff;
  rtcsc_byte_t  ram [0:63];

  logic         wr_index;
  logic         wr_data;
  logic         rd_data;
  logic         rd_flags;
  logic         rate_on;
  logic         period_hit;
  rtcsc_byte_t  rd_value;
  logic         wr_ctrl_a;
  logic         wr_ctrl_b;
  logic [15:0]  chk_ticks_ff;
  logic         chk_fresh_ff;
  logic [15:0]  chk_span;

  // Port decode.
  assign wr_index = io_wr_stb && io_port == RTCSC_PORT_INDEX;
  assign wr_data  = io_wr_stb && io_port == RTCSC_PORT_DATA;
  assign rd_data  = io_rd_stb && io_port == RTCSC_PORT_DATA;
  assign rd_flags = rd_data && index_ff == `RTCSC_IDX_FLAGS;
  assign wr_ctrl_a = wr_data && index_ff == `RTCSC_IDX_CTRL_A;
  assign wr_ctrl_b = wr_data && index_ff == `RTCSC_IDX_CTRL_B;

  // Index port: six index bits and the write-only mask bit.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      index_ff    <= `RTCSC_RST_INDEX;
      nmi_mask_ff <= 1'b1;
    end else if (wr_index) begin
      index_ff    <= io_wdata[5:0];
      nmi_mask_ff <= io_wdata[`RTCSC_BIT_NMI];
    end
  end

  // Control byte A; its top bit is the live busy input, not stored.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_a_ff <= `RTCSC_RST_CTRL_A;
    end else if (wr_data && index_ff == `RTCSC_IDX_CTRL_A) begin
      ctrl_a_ff <= {1'b0, io_wdata[6:0]};
    end
  end

  // Control byte B carries the three interrupt enables.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_b_ff <= `RTCSC_RST_CTRL_B;
    end else if (wr_data && index_ff == `RTCSC_IDX_CTRL_B) begin
      ctrl_b_ff <= io_wdata;
    end
  end

  // Configuration RAM is battery backed, so it has no reset on purpose.
  always_ff @(posedge clk) begin
    if (wr_data && !is_status(index_ff)) begin
      ram[index_ff] <= io_wdata;
    end
  end

  // Power valid drops once the battery fails and stays down until reset.
  // There is no write path into it at all.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      valid_ff <= 1'b1;
    end else if (!battery_ok) begin
      valid_ff <= 1'b0;
    end
  end

  // The rate divider only runs with the normal time base selected.
  assign rate_on    = ctrl_a_ff[6:4] == `RTCSC_DIV_NORMAL &&
                      ctrl_a_ff[3:0] != 4'h0;
  assign period_hit = time_base_tick && rate_on &&
                      div_cnt_ff >= period_last(ctrl_a_ff[3:0]);

  // Counting with >= lets a rate change to a shorter period take effect
  // at the next tick instead of wrapping the counter.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_ff <= 15'h0000;
    end else if (!rate_on) begin
      div_cnt_ff <= 15'h0000;
    end else if (period_hit) begin
      div_cnt_ff <= 15'h0000;
    end else if (time_base_tick) begin
      div_cnt_ff <= div_cnt_ff + 15'h0001;
    end
  end

  // Event sources and enables toward the flag keeper.
  assign evt.periodic_evt = period_hit;
  assign evt.alarm_evt    = alarm_match;
  assign evt.update_evt   = update_done;
  assign evt.enable       = ctrl_b_ff[6:4];
  assign evt.clear        = rd_flags;

  rtcsc_flags u_flags (
    .clk (clk),
    .rst (rst),
    .evt (evt)
  );

  // Read mux; reserved bits of the flag and power bytes read as zero.
  always_comb begin
    rd_value = ram[index_ff];
    case (index_ff)
      `RTCSC_IDX_CTRL_A: rd_value = {update_busy, ctrl_a_ff[6:0]};
      `RTCSC_IDX_CTRL_B: rd_value = ctrl_b_ff;
      `RTCSC_IDX_FLAGS:  rd_value = {evt.flags, 4'h0};
      `RTCSC_IDX_POWER:  rd_value = {valid_ff, 7'h00};
      default:           rd_value = ram[index_ff];
    endcase
  end

  // Read data is captured on the strobe and holds until the next read,
  // so the flag byte returns its value from before the clear.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (io_rd_stb) begin
      rdata_ff <= (io_port == RTCSC_PORT_DATA) ? rd_value : {2'h0, index_ff};
    end
  end

  assign io_rdata = rdata_ff;
  assign nmi_mask = nmi_mask_ff;
  assign irq      = evt.flags[3];

  // Checker-only count of time-base ticks since the last periodic event.
  // Any write to control byte A starts a fresh period, because a shorter
  // rate may legally end the running one early; only whole periods after
  // that are held to the exact length.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chk_ticks_ff <= 16'h0000;
      chk_fresh_ff <= 1'b1;
    end else if (wr_ctrl_a) begin
      chk_ticks_ff <= 16'h0000;
      chk_fresh_ff <= 1'b1;
    end else if (period_hit) begin
      chk_ticks_ff <= 16'h0000;
      chk_fresh_ff <= 1'b0;
    end else if (time_base_tick && rate_on) begin
      chk_ticks_ff <= chk_ticks_ff + 16'h0001;
    end
  end

  // Expected ticks in one period, minus one, for the selected rate.
  assign chk_span = (16'h0001 << (ctrl_a_ff[3:0] - 4'h1)) - 16'h0001;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_irq_release: assert property (
    rd_flags && !period_hit && !alarm_match && !update_done |=> !irq)
    else $error("Interrupt still raised after flag read.");
  a_flag_reserved: assert property (
    rd_flags |=> io_rdata[3:0] == 4'h0 && io_rdata[7] == $past(irq))
    else $error("Flag byte read returned wrong value.");
  a_power_sticky: assert property (
    !battery_ok |=> !valid_ff [*3])
    else $error("Power valid recovered without reset.");
  a_power_read: assert property (
    rd_data && index_ff == `RTCSC_IDX_POWER |=>
    io_rdata == {$past(valid_ff), 7'h00})
    else $error("Power byte read returned wrong value.");
  a_ram_route: assert property (
    wr_data && !is_status(index_ff) ##1 rd_data && !wr_index |=>
    io_rdata == $past(io_wdata, 2))
    else $error("RAM byte did not read back its write.");
  a_rate_zero: assert property (
    ctrl_a_ff[3:0] == 4'h0 |-> !period_hit)
    else $error("Periodic event with rate select zero.");
  a_ctrl_b_en: assert property (
    wr_data && index_ff == `RTCSC_IDX_CTRL_B |=>
    evt.enable == $past(io_wdata[6:4]))
    else $error("Enables do not follow control byte B.");

  // Register port checks: index, mask bit, read data and write paths.
  a_index_write: assert property (
    wr_index |=> index_ff == $past(io_wdata[5:0]))
    else $error("Index port write did not select the byte.");
  a_mask_write: assert property (
    wr_index |=> nmi_mask == $past(io_wdata[`RTCSC_BIT_NMI]))
    else $error("Mask bit does not follow the index write.");
  a_index_read: assert property (
    io_rd_stb && io_port == RTCSC_PORT_INDEX |=>
    io_rdata == {2'h0, $past(index_ff)})
    else $error("Index port read returned wrong value.");
  a_rdata_hold: assert property (
    !io_rd_stb |=> $stable(io_rdata))
    else $error("Read data changed without a read strobe.");
  a_busy_live: assert property (
    rd_data && index_ff == `RTCSC_IDX_CTRL_A |=>
    io_rdata[7] == $past(update_busy))
    else $error("Busy bit of control byte A not live.");
  a_ctrl_a_write: assert property (
    wr_ctrl_a |=> ctrl_a_ff == {1'b0, $past(io_wdata[6:0])})
    else $error("Control byte A did not take its write.");
  a_ctrl_b_write: assert property (
    wr_ctrl_b |=> ctrl_b_ff == $past(io_wdata))
    else $error("Control byte B did not take its write.");

  // Status byte checks: both bytes ignore writes, power valid holds while the battery is good.
  a_power_ro: assert property (
    wr_data && index_ff == `RTCSC_IDX_POWER && battery_ok |=>
    valid_ff == $past(valid_ff))
    else $error("Write changed the power valid bit.");
  a_power_kept: assert property (
    valid_ff && battery_ok |=> valid_ff)
    else $error("Power valid fell with good backup power.");
  a_flags_ro: assert property (
    wr_data && index_ff == `RTCSC_IDX_FLAGS && !period_hit &&
    !alarm_match && !update_done |=> evt.flags == $past(evt.flags))
    else $error("Write changed the flag byte.");

  // Interrupt checks: enabled events raise the request, and it stays up
  // until the flag byte is read or the enables are rewritten.
  a_periodic_irq: assert property (
    period_hit && evt.enable[2] && !wr_ctrl_b |=> irq)
    else $error("Enabled periodic event raised no interrupt.");
  a_alarm_irq: assert property (
    alarm_match && evt.enable[1] && !wr_ctrl_b |=> irq)
    else $error("Enabled alarm event raised no interrupt.");
  a_update_irq: assert property (
    update_done && evt.enable[0] && !wr_ctrl_b |=> irq)
    else $error("Enabled update event raised no interrupt.");
  a_irq_hold: assert property (
    irq && !rd_flags && !wr_ctrl_b |=> irq)
    else $error("Interrupt dropped without a flag read.");
  a_irq_cause: assert property (
    !irq && !period_hit && !alarm_match && !update_done &&
    !wr_ctrl_b |=> !irq)
    else $error("Interrupt raised without an event.");

  // Periodic checks; the period length checks use the checker-only tick count above.
  a_rate_div: assert property (
    ctrl_a_ff[6:4] != `RTCSC_DIV_NORMAL |-> !period_hit)
    else $error("Periodic event with another time base selected.");
  a_period_len: assert property (
    period_hit && !chk_fresh_ff |-> chk_ticks_ff == chk_span)
    else $error("Periodic event came at the wrong tick.");
  a_period_due: assert property (
    time_base_tick && rate_on && !chk_fresh_ff &&
    chk_ticks_ff == chk_span |-> period_hit)
    else $error("Periodic event missed at the end of its period.");
  c_irq_rise: cover property (!irq ##1 irq);
  c_flag_read: cover property (irq ##0 rd_flags ##1 !irq);
  c_power_loss: cover property (valid_ff ##1 !valid_ff);
endmodule

//--- hw/rtcsc_defines.svh
/*
  Constants of the clock status block: byte indices, field positions,
  reset values and firmware byte codes.
  Assumes it is included by its bare name from the top, flag keeper and bench files.
*/
`ifndef RTCSC_DEFINES_SVH
`define RTCSC_DEFINES_SVH

// Byte indices behind the index port.
`define RTCSC_IDX_CTRL_A     6'h0a
`define RTCSC_IDX_CTRL_B     6'h0b
`define RTCSC_IDX_FLAGS      6'h0c
`define RTCSC_IDX_POWER      6'h0d
`define RTCSC_IDX_DIAG       6'h0e
`define RTCSC_IDX_SHUTDOWN   6'h0f
`define RTCSC_IDX_FLOPPY     6'h10
`define RTCSC_IDX_HDISK      6'h11
`define RTCSC_IDX_EQUIP      6'h14

// Field positions.
`define RTCSC_BIT_IRQF       7
`define RTCSC_BIT_PF         6
`define RTCSC_BIT_AF         5
`define RTCSC_BIT_UF         4
`define RTCSC_BIT_VALID      7
`define RTCSC_BIT_NMI        7
`define RTCSC_BIT_BUSY       7

// Reset values and the normal time-base divider select.
`define RTCSC_RST_CTRL_A     8'h26
`define RTCSC_RST_CTRL_B     8'h02
`define RTCSC_RST_INDEX      6'h0d
`define RTCSC_DIV_NORMAL     3'h2

// Codes that firmware keeps in the configuration bytes.
`define RTCSC_FLOPPY_NONE    4'h0
`define RTCSC_FLOPPY_720K    4'h3
`define RTCSC_FLOPPY_1M44    4'h4
`define RTCSC_HDISK_NONE     8'h00

`endif

//--- hw/rtcsc_pkg.sv
/*
  Types shared by the clock status block.
  Assumes nothing of its surroundings.
*/
package rtcsc_pkg;
  typedef enum logic {RTCSC_PORT_INDEX, RTCSC_PORT_DATA} rtcsc_port_t;
  typedef logic [5:0] rtcsc_index_t;
  typedef logic [7:0] rtcsc_byte_t;
endpackage

//--- hw/rtcsc_evt_if.sv
/*
  Event and flag signals between the register front end and the flag
  keeper.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface rtcsc_evt_if;
  logic       periodic_evt;
  logic       alarm_evt;
  logic       update_evt;
  logic [2:0] enable;
  logic       clear;
  logic [3:0] flags;
  modport owner (
    input  periodic_evt,
    input  alarm_evt,
    input  update_evt,
    input  enable,
    input  clear,
    output flags
  );
  modport user (
    output periodic_evt,
    output alarm_evt,
    output update_evt,
    output enable,
    output clear,
    input  flags
  );
endinterface

//--- hw/rtcsc_flags.sv
/*
  Sticky event flags and the summary request.
  Assumes events and the clear are one-cycle pulses on clk.
*/
`timescale 1ns/1ps
`include "rtcsc_defines.svh"
module rtcsc_flags (
  input wire logic   clk,
  input wire logic   rst,
  rtcsc_evt_if.owner evt
);
  import rtcsc_pkg::*;

  logic [2:0] set_vec;
  logic [2:0] type_vec;
  logic       irqf;

  // Order is periodic, alarm, update, matching flag bits 6 to 4.
  assign set_vec = {evt.periodic_evt, evt.alarm_evt, evt.update_evt};

  // One sticky flag per event; a set in the clearing cycle wins so that
  // an event arriving during the flag read is never lost.
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_flag
      logic flag_ff;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          flag_ff <= 1'b0;
        end else if (set_vec[i]) begin
          flag_ff <= 1'b1;
        end else if (evt.clear) begin
          flag_ff <= 1'b0;
        end
      end
      assign type_vec[i] = flag_ff;
    end
  endgenerate

  // Summary is the enabled flags; flags themselves set unconditionally.
  assign irqf = |(type_vec & evt.enable);
  assign evt.flags = {irqf, type_vec};

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_pf_set: assert property (evt.periodic_evt |=> type_vec[2])
    else $error("Periodic flag not set after event.");
  a_af_set: assert property (evt.alarm_evt |=> type_vec[1])
    else $error("Alarm flag not set after event.");
  a_uf_set: assert property (evt.update_evt |=> type_vec[0])
    else $error("Update flag not set after event.");
  a_clear_empties: assert property (
    evt.clear && set_vec == 3'h0 |=> type_vec == 3'h0)
    else $error("Flags survive a clear without events.");
  a_summary_gate: assert property (
    evt.periodic_evt && evt.enable[2] && !evt.clear |=> irqf ##0
    evt.flags[3])
    else $error("Enabled periodic event did not raise summary.");
  a_masked_quiet: assert property (
    evt.enable == 3'h0 |-> !irqf)
    else $error("Summary raised with all enables off.");
  c_periodic_irq: cover property (evt.periodic_evt && evt.enable[2]);
  c_set_on_clear: cover property (evt.clear && set_vec != 3'h0);
endmodule

//--- test/tb_top.sv
/*
  Self-checking bench for the clock status byte block.
  Assumes the block answers reads one cycle after the strobe edge and
  that events are one-cycle pulses on clk.
*/
`timescale 1ns/1ps
`include "rtcsc_defines.svh"
module tb_top;
  import rtcsc_pkg::*;
  logic        clk;
  logic        rst;
  rtcsc_port_t io_port;
  logic        io_wr_stb;
  logic        io_rd_stb;
  rtcsc_byte_t io_wdata;
  rtcsc_byte_t io_rdata;
  logic        time_base_tick;
  logic        alarm_match;
  logic        update_done;
  logic        update_busy;
  logic        battery_ok;
  logic        irq;
  logic        nmi_mask;
  int          err_total;
  int          cmp_count;
  rtcsc_byte_t v;

  rtcsc_top rtcsc_top_i (
    .clk(clk), .rst(rst), .io_port(io_port), .io_wr_stb(io_wr_stb),
    .io_rd_stb(io_rd_stb), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .time_base_tick(time_base_tick), .alarm_match(alarm_match),
    .update_done(update_done), .update_busy(update_busy),
    .battery_ok(battery_ok), .irq(irq), .nmi_mask(nmi_mask));

  // The clock runs at 10 MHz.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string nm, input rtcsc_byte_t exp,
                       input rtcsc_byte_t seen);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Each access raises its strobe for exactly one taken edge.
  task automatic wr(input rtcsc_port_t p, input rtcsc_byte_t d);
    @(posedge clk);
    io_port   <= p;
    io_wdata  <= d;
    io_wr_stb <= 1'b1;
    @(posedge clk);
    io_wr_stb <= 1'b0;
  endtask

  // Read data is sampled a full cycle after the strobe so it has settled.
  task automatic rd(input rtcsc_port_t p, output rtcsc_byte_t d);
    @(posedge clk);
    io_port   <= p;
    io_rd_stb <= 1'b1;
    @(posedge clk);
    io_rd_stb <= 1'b0;
    @(posedge clk);
    #1 d = io_rdata;
  endtask

  task automatic reg_wr(input rtcsc_index_t i, input rtcsc_byte_t d);
    wr(RTCSC_PORT_INDEX, {2'b00, i});
    wr(RTCSC_PORT_DATA, d);
  endtask

  task automatic reg_rd(input rtcsc_index_t i, output rtcsc_byte_t d);
    wr(RTCSC_PORT_INDEX, {2'b00, i});
    rd(RTCSC_PORT_DATA, d);
  endtask

  // Source 0 periodic tick, 1 alarm, 2 update end; one settle edge after.
  task automatic pulse(input int src);
    @(posedge clk);
    time_base_tick <= (src == 0);
    alarm_match    <= (src == 1);
    update_done    <= (src == 2);
    @(posedge clk);
    time_base_tick <= 1'b0;
    alarm_match    <= 1'b0;
    update_done    <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic t_reset;
    rd(RTCSC_PORT_INDEX, v);
    check("index", 8'h0d, v);
    check("nmi_mask", 8'h01, {7'h00, nmi_mask});
    rd(RTCSC_PORT_DATA, v);
    check("power", 8'h80, v);
    reg_rd(`RTCSC_IDX_FLAGS, v);
    check("flags", 8'h00, v);
    reg_rd(`RTCSC_IDX_CTRL_A, v);
    check("ctrl_a", `RTCSC_RST_CTRL_A, v);
    $display("Reset test done");
  endtask

  // Writes to both status bytes must be ignored.
  task automatic t_readonly;
    reg_wr(`RTCSC_IDX_POWER, 8'h00);
    reg_rd(`RTCSC_IDX_POWER, v);
    check("power_ro", 8'h80, v);
    reg_wr(`RTCSC_IDX_FLAGS, 8'hff);
    reg_rd(`RTCSC_IDX_FLAGS, v);
    check("flags_ro", 8'h00, v);
    check("irq_ro", 8'h00, {7'h00, irq});
    $display("Read-only test done");
  endtask

  task automatic t_events;
    // Rate one makes every single tick a periodic event.
    reg_wr(`RTCSC_IDX_CTRL_A, 8'h21);
    reg_wr(`RTCSC_IDX_CTRL_B, 8'h72);
    for (int s = 0; s < 3; s++) begin
      pulse(s);
      check("irq_set", 8'h01, {7'h00, irq});
      reg_rd(`RTCSC_IDX_FLAGS, v);
      check("flag_kind", 8'h80 | (8'h40 >> s), v);
      check("irq_clr", 8'h00, {7'h00, irq});
    end
    // With enables off the flag still sets but no request follows.
    reg_wr(`RTCSC_IDX_CTRL_B, `RTCSC_RST_CTRL_B);
    pulse(1);
    check("irq_off", 8'h00, {7'h00, irq});
    reg_rd(`RTCSC_IDX_FLAGS, v);
    check("flag_off", 8'h20, v);
    pulse(2);
    reg_rd(`RTCSC_IDX_FLAGS, v);
    check("flag_upd", 8'h10, v);
    $display("Event test done");
  endtask

  // Rate 3 gives a periodic event every fourth tick.
  task automatic t_periodic;
    reg_wr(`RTCSC_IDX_CTRL_A, 8'h23);
    reg_wr(`RTCSC_IDX_CTRL_B, 8'h42);
    repeat (3) pulse(0);
    check("per_early", 8'h00, {7'h00, irq});
    pulse(0);
    check("per_irq", 8'h01, {7'h00, irq});
    reg_rd(`RTCSC_IDX_FLAGS, v);
    check("per_flag", 8'hc0, v);
    @(posedge clk);
    update_busy <= 1'b1;
    reg_rd(`RTCSC_IDX_CTRL_A, v);
    check("busy_bit", 8'ha3, v);
    @(posedge clk);
    update_busy <= 1'b0;
    $display("Periodic test done");
  endtask

  task automatic t_ram;
    rtcsc_index_t ix [5];
    rtcsc_byte_t  dv [5];
    ix = '{`RTCSC_IDX_DIAG, `RTCSC_IDX_SHUTDOWN, `RTCSC_IDX_FLOPPY,
           `RTCSC_IDX_HDISK, `RTCSC_IDX_EQUIP};
    dv = '{8'h81, 8'h5a, {`RTCSC_FLOPPY_720K, 4'h0}, `RTCSC_HDISK_NONE,
           8'h23};
    foreach (ix[k]) reg_wr(ix[k], dv[k]);
    foreach (ix[k]) begin
      reg_rd(ix[k], v);
      check("ram_byte", dv[k], v);
    end
    check("nmi_clear", 8'h00, {7'h00, nmi_mask});
    // Every floppy drive code must survive a round trip.
    foreach (dv[k]) begin
      if (k < 3) begin
        reg_wr(`RTCSC_IDX_FLOPPY, {4'h0 + (k == 1 ? `RTCSC_FLOPPY_720K :
               k == 2 ? `RTCSC_FLOPPY_1M44 : `RTCSC_FLOPPY_NONE), 4'h0});
        reg_rd(`RTCSC_IDX_FLOPPY, v);
        check("floppy", {(k == 1 ? `RTCSC_FLOPPY_720K : k == 2 ?
              `RTCSC_FLOPPY_1M44 : `RTCSC_FLOPPY_NONE), 4'h0}, v);
      end
    end
    // A read in the cycle right after a data write sees the new byte.
    @(posedge clk);
    io_port   <= RTCSC_PORT_DATA;
    io_wdata  <= {`RTCSC_FLOPPY_NONE, 4'h0};
    io_wr_stb <= 1'b1;
    @(posedge clk);
    io_wr_stb <= 1'b0;
    io_rd_stb <= 1'b1;
    @(posedge clk);
    io_rd_stb <= 1'b0;
    @(posedge clk);
    #1 check("ram_b2b", {`RTCSC_FLOPPY_NONE, 4'h0}, io_rdata);
    // Bit 7 of an index write sets the mask.
    wr(RTCSC_PORT_INDEX, {2'b10, `RTCSC_IDX_EQUIP});
    #1 check("nmi_set", 8'h01, {7'h00, nmi_mask});
    $display("RAM test done");
  endtask

  // A dip in backup power must be remembered after it recovers.
  task automatic t_power;
    @(posedge clk);
    battery_ok <= 1'b0;
    repeat (2) @(posedge clk);
    battery_ok <= 1'b1;
    reg_rd(`RTCSC_IDX_POWER, v);
    check("power_lost", 8'h00, v);
    $display("Power test done");
  endtask

  // Main sequence: reset for ten cycles, then every scenario in turn.
  initial begin
    err_total = 0;
    cmp_count = 0;
    rst = 1'b1;
    io_port = RTCSC_PORT_INDEX;
    io_wr_stb = 1'b0;
    io_rd_stb = 1'b0;
    io_wdata = 8'h00;
    time_base_tick = 1'b0;
    alarm_match = 1'b0;
    update_done = 1'b0;
    update_busy = 1'b0;
    battery_ok = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_readonly();
    t_events();
    t_periodic();
    t_ram();
    t_power();
    report_and_stop();
  end

  // The scenarios need well under a thousand cycles; allow five thousand.
  initial begin
    #500000;
    err_total++;
    report_and_stop();
  end
endmodule
